// file: rtl/tsm_sensor_ctrl.sv
// Bus target, configuration register and conversion control of the sensor.
//
// Functional notes
// - Answer only bus transactions addressed to seven-bit address 1001 110.
// - Halt bit 6 low: convert continuously without further commands.
// - Halt bit written high: abort conversion at once, enter standby.
// - In standby each one-shot command received while no conversion is running starts exactly one conversion.
// - Mask bit 7 high holds the alert output deasserted.
// - Reset clears every configuration bit to zero.
// - Assert alert when temperature lies beyond the upper or lower limit.
`timescale 1ns/100ps
`default_nettype none
`include "tsm_cfg.svh"

module tsm_sensor_ctrl (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic SMB_CLK,
   input wire logic SMB_DAT_I,
   output logic SMB_DAT_O,
   output logic SMB_DAT_OE,
   output logic ALERT_N_O,
   output logic ALERT_N_OE,
   output logic CONV_START,
   output logic CONV_ABORT,
   input wire logic CONV_DONE,
   input wire logic [7:0] CONV_RESULT,
   output logic STANDBY
);

   // =======================================================================
   // State
   tsm_pkg::tsm_slave_st_t sl_st_r;
   tsm_pkg::tsm_conv_st_t cv_st_r;
   tsm_pkg::tsm_cfg_t cfg_r;
   logic scl_q_r, sda_q_r;
   logic [3:0] cnt_r;
   logic [7:0] shift_r, tx_r, cmd_r, wdata_r, temp_r, hi_r, lo_r;
   logic rd_r, ph_r, nack_r, wr_stb_r, shot_req_r, halt_q_r;
   logic oe_r, alert_oe_r, conv_start_r, conv_abort_r, standby_r;

   // =======================================================================
   // Bus line events and decode
   wire scl_rise_w = SMB_CLK & ~scl_q_r;
   wire scl_fall_w = ~SMB_CLK & scl_q_r;
   wire start_w = SMB_CLK & scl_q_r & sda_q_r & ~SMB_DAT_I;
   wire stop_w = SMB_CLK & scl_q_r & ~sda_q_r & SMB_DAT_I;
   wire byte_done_w = (cnt_r == `TSM_BIT_COUNT);
   wire addr_hit_w = (shift_r[7:1] == `TSM_SMB_ADDR);
   wire [7:0] cfg_byte_w = {cfg_r.mask, cfg_r.halt, 6'h00};
   wire [7:0] rd_byte_w =
      (cmd_r == `TSM_CMD_RD_TEMP) ? temp_r :
      (cmd_r == `TSM_CMD_RD_CFG) ? cfg_byte_w :
      (cmd_r == `TSM_CMD_RD_HI) ? hi_r :
      (cmd_r == `TSM_CMD_RD_LO) ? lo_r : 8'h00;
   wire halt_rise_w = cfg_r.halt & ~halt_q_r;
   wire out_of_range_w = (temp_r > hi_r) || (temp_r < lo_r);

   // =======================================================================
   // Bus target
   // Inputs are synchronous, so edges are found by one stage of delay.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         sl_st_r <= tsm_pkg::SL_IDLE;
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         cmd_r <= 8'h00;
         wdata_r <= 8'h00;
         rd_r <= 1'b0;
         ph_r <= 1'b0;
         nack_r <= 1'b1;
         wr_stb_r <= 1'b0;
         shot_req_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         scl_q_r <= SMB_CLK;
         sda_q_r <= SMB_DAT_I;
         wr_stb_r <= 1'b0;
         shot_req_r <= 1'b0;
         if (start_w) begin
            sl_st_r <= tsm_pkg::SL_ADDR;
            cnt_r <= 4'h0;
            oe_r <= 1'b0;
         end else if (stop_w) begin
            sl_st_r <= tsm_pkg::SL_IDLE;
            oe_r <= 1'b0;
         end else if (scl_rise_w) begin
            shift_r <= {shift_r[6:0], SMB_DAT_I};
            cnt_r <= 4'(cnt_r + 4'h1);
            nack_r <= SMB_DAT_I;
         end else if (scl_fall_w) begin
            case (sl_st_r)
               tsm_pkg::SL_ADDR: begin
                  if (byte_done_w && addr_hit_w) begin
                     oe_r <= 1'b1;
                     rd_r <= shift_r[0];
                     ph_r <= 1'b0;
                     sl_st_r <= tsm_pkg::SL_ACK;
                  end else if (byte_done_w) begin
                     sl_st_r <= tsm_pkg::SL_IGNORE;
                  end
               end
               tsm_pkg::SL_ACK: begin
                  cnt_r <= 4'h0;
                  if (rd_r) begin
                     tx_r <= rd_byte_w;
                     oe_r <= ~rd_byte_w[7];
                     sl_st_r <= tsm_pkg::SL_TX;
                  end else begin
                     oe_r <= 1'b0;
                     sl_st_r <= ph_r ? tsm_pkg::SL_DATA : tsm_pkg::SL_CMD;
                  end
               end
               tsm_pkg::SL_CMD: begin
                  if (byte_done_w) begin
                     cmd_r <= shift_r;
                     shot_req_r <= (shift_r == `TSM_CMD_ONE_SHOT);
                     oe_r <= 1'b1;
                     ph_r <= 1'b1;
                     sl_st_r <= tsm_pkg::SL_ACK;
                  end
               end
               tsm_pkg::SL_DATA: begin
                  if (byte_done_w) begin
                     wdata_r <= shift_r;
                     wr_stb_r <= 1'b1;
                     oe_r <= 1'b1;
                     sl_st_r <= tsm_pkg::SL_ACK;
                  end
               end
               tsm_pkg::SL_TX: begin
                  if (byte_done_w) begin
                     oe_r <= 1'b0;
                     sl_st_r <= tsm_pkg::SL_MACK;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     oe_r <= ~tx_r[6];
                  end
               end
               tsm_pkg::SL_MACK: begin
                  if (!nack_r) begin
                     tx_r <= rd_byte_w;
                     oe_r <= ~rd_byte_w[7];
                     cnt_r <= 4'h0;
                     sl_st_r <= tsm_pkg::SL_TX;
                  end else begin
                     sl_st_r <= tsm_pkg::SL_IGNORE;
                  end
               end
               default: begin
                  oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // =======================================================================
   // Registers written over the bus
   // Reserved bits are not stored; they always read back as zero.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cfg_r <= `TSM_CFG_RESET;
         hi_r <= `TSM_HI_RESET;
         lo_r <= `TSM_LO_RESET;
      end else if (wr_stb_r) begin
         if (cmd_r == `TSM_CMD_WR_CFG) begin
            cfg_r.mask <= wdata_r[`TSM_CFG_MASK_BIT];
            cfg_r.halt <= wdata_r[`TSM_CFG_HALT_BIT];
            cfg_r.reserved_bits <= 6'h00;
         end
         if (cmd_r == `TSM_CMD_WR_HI) begin
            hi_r <= wdata_r;
         end
         if (cmd_r == `TSM_CMD_WR_LO) begin
            lo_r <= wdata_r;
         end
      end
   end

   // =======================================================================
   // Conversion control
   // A one-shot in continuous mode is ignored; its result is undefined.
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         cv_st_r <= tsm_pkg::CV_IDLE;
         conv_start_r <= 1'b0;
         conv_abort_r <= 1'b0;
         temp_r <= 8'h00;
         halt_q_r <= 1'b0;
         standby_r <= 1'b0;
         alert_oe_r <= 1'b0;
      end else begin
         halt_q_r <= cfg_r.halt;
         standby_r <= cfg_r.halt;
         conv_start_r <= 1'b0;
         conv_abort_r <= 1'b0;
         alert_oe_r <= ~cfg_r.mask & out_of_range_w;
         case (cv_st_r)
            tsm_pkg::CV_IDLE: begin
               if (!cfg_r.halt || shot_req_r) begin
                  conv_start_r <= 1'b1;
                  cv_st_r <= tsm_pkg::CV_BUSY;
               end
            end
            tsm_pkg::CV_BUSY: begin
               if (halt_rise_w) begin
                  conv_abort_r <= 1'b1;
                  cv_st_r <= tsm_pkg::CV_IDLE;
               end else if (CONV_DONE) begin
                  temp_r <= CONV_RESULT;
                  cv_st_r <= tsm_pkg::CV_IDLE;
               end
            end
            default: begin
               cv_st_r <= tsm_pkg::CV_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // Outputs
   // Both lines are open drain, so the driven level is a constant low.
   logic sda_o_r, alert_o_r;
   always_ff @(posedge CLOCK) begin
      sda_o_r <= 1'b0;
      alert_o_r <= 1'b0;
   end

   assign SMB_DAT_O = sda_o_r;
   assign SMB_DAT_OE = oe_r;
   assign ALERT_N_O = alert_o_r;
   assign ALERT_N_OE = alert_oe_r;
   assign CONV_START = conv_start_r;
   assign CONV_ABORT = conv_abort_r;
   assign STANDBY = standby_r;

endmodule
`default_nettype wire

// file: rtl/tsm_cfg.svh
// Constants of the thermal sensor mode control block.
`ifndef TSM_CFG_SVH
`define TSM_CFG_SVH

// ==========================================================================
// Bus target address and command codes
`define TSM_SMB_ADDR 7'h4E
`define TSM_CMD_RD_TEMP 8'h00
`define TSM_CMD_RD_CFG 8'h03
`define TSM_CMD_RD_HI 8'h07
`define TSM_CMD_RD_LO 8'h08
`define TSM_CMD_WR_CFG 8'h09
`define TSM_CMD_WR_HI 8'h0D
`define TSM_CMD_WR_LO 8'h0E
`define TSM_CMD_ONE_SHOT 8'h0F

// ==========================================================================
// Configuration byte layout and reset values
`define TSM_CFG_MASK_BIT 7
`define TSM_CFG_HALT_BIT 6
`define TSM_CFG_RESET 8'h00
`define TSM_HI_RESET 8'h7F
`define TSM_LO_RESET 8'h00
`define TSM_BIT_COUNT 4'h8

`endif

// file: rtl/tsm_pkg.sv
// Types of the thermal sensor mode control block.
package tsm_pkg;

   // =======================================================================
   // Configuration register
   typedef struct packed {
      logic mask;
      logic halt;
      logic [5:0] reserved_bits;
   } tsm_cfg_t;

   // =======================================================================
   // State machines
   typedef enum logic [2:0] {
      SL_IDLE,
      SL_ADDR,
      SL_ACK,
      SL_CMD,
      SL_DATA,
      SL_TX,
      SL_MACK,
      SL_IGNORE
   } tsm_slave_st_t;

   typedef enum logic {
      CV_IDLE,
      CV_BUSY
   } tsm_conv_st_t;

endpackage

// file: testbench/tsm_host_mdl.sv
// Bus host model that drives the sensor's two-wire interface.
`timescale 1ns/100ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_host_mdl (
   input wire logic clk,
   input wire logic dev_oe,
   output logic scl,
   output logic sda
);
   // ==========
   // Wire and bus cycles
   logic drv = 1'b1;
   // The data line has a pull-up, so a released line reads one.
   assign sda = drv & ~dev_oe;
   initial scl = 1'b1;
   task automatic t(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic bit_io(input logic b, output logic r);
      drv = b;
      t(2);
      scl = 1'b1;
      t(2);
      r = sda;
      t(2);
      scl = 1'b0;
      t(3);
   endtask
   task automatic xb(input logic [7:0] d, output logic [7:0] q,
                     output logic nak);
      logic rb;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], rb);
         q = {q[6:0], rb};
      end
      bit_io(1'b1, nak);
   endtask
   task automatic sta();
      drv = 1'b1;
      t(3);
      scl = 1'b1;
      t(4);
      drv = 1'b0;
      t(4);
      scl = 1'b0;
      t(3);
   endtask
   task automatic sto();
      drv = 1'b0;
      t(3);
      scl = 1'b1;
      t(4);
      drv = 1'b1;
      t(4);
   endtask
   // Reserved bits are always written as zero by the callers.
   task automatic wr(input logic [6:0] a, input logic [7:0] c, d,
                     output logic nak);
      logic [7:0] q;
      logic n0, n1, n2;
      sta();
      xb({a, 1'b0}, q, n0);
      xb(c, q, n1);
      xb(d, q, n2);
      sto();
      nak = n0 | n1 | n2;
   endtask
   // One-shot is only used in standby; monitoring uses continuous mode.
   task automatic snd(input logic [7:0] c);
      logic [7:0] q;
      logic n;
      sta();
      xb({`TSM_SMB_ADDR, 1'b0}, q, n);
      xb(c, q, n);
      sto();
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] q);
      logic n;
      sta();
      xb({`TSM_SMB_ADDR, 1'b0}, q, n);
      xb(c, q, n);
      sta();
      xb({`TSM_SMB_ADDR, 1'b1}, q, n);
      xb(8'hFF, q, n);
      sto();
   endtask
endmodule
`default_nettype wire

// file: testbench/tsm_sensor_ctrl_sva.sv
// Port assertions of the sensor control block.
`timescale 1ns/100ps
`default_nettype none
module tsm_sensor_ctrl_sva (
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic SMB_CLK,
   input wire logic SMB_DAT_O,
   input wire logic SMB_DAT_OE,
   input wire logic ALERT_N_O,
   input wire logic CONV_START,
   input wire logic CONV_ABORT,
   input wire logic CONV_DONE,
   input wire logic STANDBY
);
   // ==========
   // Assertions
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   a_start_pulse: assert property (CONV_START |=> !CONV_START)
      else $error("start pulse too long");
   a_abort_pulse: assert property (CONV_ABORT |=> !CONV_ABORT)
      else $error("abort pulse too long");
   a_abort_standby: assert property (CONV_ABORT |-> STANDBY)
      else $error("abort outside standby");
   a_abort_quiet: assert property (CONV_ABORT |=> !CONV_START [*8])
      else $error("start right after abort");
   // A halt written as the conversion ends is not a continuous-mode restart.
   a_cont_restart: assert property (CONV_DONE && !STANDBY |->
      ##[1:3] (CONV_START || STANDBY))
      else $error("no restart in continuous mode");
   a_reset_clear: assert property (disable iff (1'b0) !RST_N |=>
      !STANDBY && !CONV_START)
      else $error("outputs active after reset");
   a_drive_low: assert property (!SMB_DAT_O && !ALERT_N_O)
      else $error("open-drain value not low");
   a_ack_clk_low: assert property ($rose(SMB_DAT_OE) |-> !SMB_CLK)
      else $error("data driven with clock high");
endmodule
`default_nettype wire

// file: testbench/tsm_sensor_ctrl_tb.sv
// Self-checking bench of the sensor control block.
`timescale 1ns/100ps
`default_nettype none
`include "tsm_cfg.svh"
module tsm_sensor_ctrl_tb;
   logic clock, rst_n, nak, standby, start, abort, dat_o, dat_oe, al_o, al_oe;
   wire logic scl, sda;
   logic done = 1'b0;
   logic [7:0] temp, q, d;
   logic [7:0] res = 8'h00;
   logic [6:0] a;
   logic [7:0] hi_v = `TSM_HI_RESET;
   logic [7:0] lo_v = `TSM_LO_RESET;
   int err_count, samples_checked, n_start, w, s;
   tsm_sensor_ctrl uut (.CLOCK(clock), .RST_N(rst_n), .SMB_CLK(scl),
      .SMB_DAT_I(sda), .SMB_DAT_O(dat_o), .SMB_DAT_OE(dat_oe),
      .ALERT_N_O(al_o), .ALERT_N_OE(al_oe), .CONV_START(start),
      .CONV_ABORT(abort), .CONV_DONE(done), .CONV_RESULT(res),
      .STANDBY(standby));
   tsm_host_mdl host (.clk(clock), .dev_oe(dat_oe), .scl(scl), .sda(sda));
   // ==========
   // Converter stand-in, checks and closing
   always @(negedge clock) begin
      done <= 1'b0;
      if (!rst_n) begin
         w <= 0;
      end else if (start) begin
         n_start <= n_start + 1;
         w <= 20 + $urandom % 40;
      end else if (abort) begin
         w <= 0;
      end else if (w > 0) begin
         w <= w - 1;
         done <= (w == 1);
         res <= temp;
      end
   end
   function automatic logic exp_alert(input logic [7:0] t, input logic m);
      return !m && ((t > hi_v) || (t < lo_v));
   endfunction
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   initial begin
      repeat (60000) @(posedge clock);
      err_count++;
      test_done();
   end
   initial begin
      rst_n = 1'b0;
      s = $urandom(32'hD82A7868);
      temp = 8'($urandom % 8'h7F);
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      host.rd(`TSM_CMD_RD_CFG, q);
      chk("cfg after reset", q, `TSM_CFG_RESET);
      chk("converting", 8'(n_start > 1), 8'h01);
      for (int i = 0; i < 3; i++) begin
         a = 7'($urandom);
         if (a == `TSM_SMB_ADDR) a = 7'h00;
         host.wr(a, `TSM_CMD_WR_CFG, 8'h40, nak);
         chk("foreign nack", 8'(nak), 8'h01);
      end
      chk("no halt", 8'(standby), 8'h00);
      temp = 8'hF0;
      repeat (200) @(negedge clock);
      chk("alert", 8'(al_oe), 8'(exp_alert(temp, 1'b0)));
      for (int i = 0; i < 3; i++) begin
         d = {1'b1, 1'($urandom), 6'h00};
         host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_CFG, d, nak);
         chk("masked", 8'(al_oe), 8'(exp_alert(temp, 1'b1)));
         host.rd(`TSM_CMD_RD_CFG, q);
         chk("cfg", q, d);
      end
      host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_CFG, 8'h40, nak);
      repeat (20) @(negedge clock);
      s = n_start;
      repeat (400) @(negedge clock);
      chk("halted", 8'(n_start - s), 8'h00);
      chk("standby", 8'(standby), 8'h01);
      host.snd(`TSM_CMD_ONE_SHOT);
      repeat (100) @(negedge clock);
      host.snd(`TSM_CMD_ONE_SHOT);
      repeat (100) @(negedge clock);
      chk("one-shots", 8'(n_start - s), 8'h02);
      chk("unmasked", 8'(al_oe), 8'(exp_alert(temp, 1'b0)));
      host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_CFG, 8'h00, nak);
      temp = 8'($urandom % 8'h7F);
      repeat (200) @(negedge clock);
      chk("resumed", 8'(n_start - s > 3), 8'h01);
      chk("alert gone", 8'(al_oe), 8'(exp_alert(temp, 1'b0)));
      host.rd(`TSM_CMD_RD_TEMP, q);
      chk("temperature", q, temp);
      for (int i = 0; i < 3; i++) begin
         lo_v = (i == 0) ? 8'(temp + 8'h01) : `TSM_LO_RESET;
         hi_v = (i == 1) ? temp : 8'($urandom);
         host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_LO, lo_v, nak);
         host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_HI, hi_v, nak);
         chk("own ack", 8'(nak), 8'h00);
         host.rd(`TSM_CMD_RD_LO, q);
         chk("low limit", q, lo_v);
         host.rd(`TSM_CMD_RD_HI, q);
         chk("high limit", q, hi_v);
         repeat (20) @(negedge clock);
         chk("limit alert", 8'(al_oe), 8'(exp_alert(temp, 1'b0)));
      end
      host.wr(`TSM_SMB_ADDR, `TSM_CMD_WR_CFG, 8'hC0, nak);
      rst_n = 1'b0;
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      hi_v = `TSM_HI_RESET;
      lo_v = `TSM_LO_RESET;
      host.rd(`TSM_CMD_RD_CFG, q);
      chk("cfg after second reset", q, `TSM_CFG_RESET);
      host.rd(`TSM_CMD_RD_HI, q);
      chk("high limit after reset", q, `TSM_HI_RESET);
      chk("standby after reset", 8'(standby), 8'h00);
      chk("alert after reset", 8'(al_oe), 8'(exp_alert(temp, 1'b0)));
      test_done();
   end
endmodule
bind tsm_sensor_ctrl tsm_sensor_ctrl_sva chk_i (.CLOCK(CLOCK), .RST_N(RST_N),
   .SMB_CLK(SMB_CLK), .SMB_DAT_O(SMB_DAT_O), .SMB_DAT_OE(SMB_DAT_OE),
   .ALERT_N_O(ALERT_N_O), .CONV_START(CONV_START), .CONV_ABORT(CONV_ABORT),
   .CONV_DONE(CONV_DONE), .STANDBY(STANDBY));
`default_nettype wire
